/* File: rtl/ebr_ram_block.sv */
// embedded synchronous ram block, one of three size classes
// assumes user fabric logic on clk drives requests and clears; no synchroniser needed
`include "ebr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - three sizes: 32x18, 128x36, 4Kx144
// - each class supports its depth-by-width shapes
// - tdp, sdp, sp, rom, split; small no tdp
// - tdp allows any read/write pairing per port
// - sdp same-address read: old or undefined
// - single port: new data shown, per output register
// - medium hosts two half-size single ports
// - dual-port sides may differ in width
// - all inputs captured in input registers
// - write strobe self-timed from port clock
// - output registers optional, bypass reads array
// - flow-through: falling-edge read address, bypassed output
// - clears: large block only output registers
// - large block: no preload, rom by writing
// - input clear shows next edge, output at once
// - parity bit per byte, byte enables except small
module ebr_ram_block #(
   parameter logic [1:0] CLS = `EBR_CLS_MEDIUM,
   parameter logic [2:0] MODE = `EBR_MODE_SDP,
   parameter int WA = 36,
   parameter int WB = 36,
   parameter bit OUT_REG_A = 1'b1,
   parameter bit OUT_REG_B = 1'b1,
   parameter bit RDW_OLD = 1'b1,
   parameter bit FLOW_THRU = 1'b0
) (
   input wire logic clk, // block clock
   input wire logic sys_rst, // async reset, active high
   input wire logic in_clr, // async clear of input registers; ignored by the large block
   input wire logic out_clr, // async clear of output registers
   input wire ebr_pkg::ebr_req_t req_a, // port a request
   input wire ebr_pkg::ebr_req_t req_b, // port b request
   output logic [WA-1:0] q_a, // port a read data
   output logic [WB-1:0] q_b // port b read data
);
   // ****************************************************************
   // geometry
   // ****************************************************************
   localparam int BITS = (CLS == `EBR_CLS_SMALL) ? int'(`EBR_BITS_SMALL) :
      (CLS == `EBR_CLS_MEDIUM) ? int'(`EBR_BITS_MEDIUM) :
      int'(`EBR_BITS_LARGE);
   localparam int WMAX = (CLS == `EBR_CLS_SMALL) ? int'(`EBR_WMAX_SMALL) :
      (CLS == `EBR_CLS_MEDIUM) ? int'(`EBR_WMAX_MEDIUM) :
      int'(`EBR_WMAX_LARGE);
   localparam bit LARGE = (CLS == `EBR_CLS_LARGE);
   localparam bit SPLIT = (MODE == `EBR_MODE_SPLIT);
   // split mode gives each port half the storage
   localparam int SPAN = SPLIT ? BITS / 2 : BITS;
   localparam int DA = SPAN / WA;
   localparam int DB = SPAN / WB;
   localparam int LANE_A = (WA % 9 == 0) ? int'(`EBR_LANE_PAR) : int'(`EBR_LANE_PLAIN);
   localparam int LANE_B = (WB % 9 == 0) ? int'(`EBR_LANE_PAR) : int'(`EBR_LANE_PLAIN);
   // byte enables only where the class has them and a word holds bytes
   localparam bit BE_A = !(CLS == `EBR_CLS_SMALL) && (WA >= LANE_A);
   localparam bit BE_B = !(CLS == `EBR_CLS_SMALL) && (WB >= LANE_B);

   // ****************************************************************
   // port roles
   // ****************************************************************
   // refused directions are gated here, whatever user logic drives
   localparam bit A_WR = (MODE != `EBR_MODE_ROM);
   localparam bit A_RD = (MODE != `EBR_MODE_SDP);
   localparam bit B_WR = (MODE == `EBR_MODE_TDP) || SPLIT;
   localparam bit B_RD = (MODE == `EBR_MODE_SDP) || (MODE == `EBR_MODE_TDP) || SPLIT;

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   generate
      if (CLS > `EBR_CLS_LARGE) begin : g_bad_cls
         $error("unknown size class");
      end
      if (WA < 1 || WB < 1 || WA > WMAX || WB > WMAX) begin : g_bad_w
         $error("port width outside the class range");
      end
      if (LARGE && (WA < int'(`EBR_WMIN_LARGE) || WB < int'(`EBR_WMIN_LARGE))) begin : g_bad_lw
         $error("large block ports are at least one byte wide");
      end
      if (SPAN % WA != 0 || SPAN % WB != 0) begin : g_bad_shape
         $error("port width does not tile the storage");
      end
      if ($clog2(DA) > `EBR_REQ_AW || $clog2(DB) > `EBR_REQ_AW) begin : g_bad_aw
         $error("address wider than the request carrier");
      end
      if (MODE > `EBR_MODE_SPLIT) begin : g_bad_mode
         $error("unknown mode");
      end
      if (MODE == `EBR_MODE_TDP && CLS == `EBR_CLS_SMALL) begin : g_bad_tdp
         $error("small block has no true dual-port mode");
      end
      if (SPLIT && CLS != `EBR_CLS_MEDIUM) begin : g_bad_split
         $error("two single ports only in the medium block");
      end
      if (FLOW_THRU && (LARGE || MODE != `EBR_MODE_SDP || OUT_REG_B)) begin : g_bad_ft
         $error("flow-through needs small/medium, sdp, bypassed port b output");
      end
      if (WA > `EBR_REQ_DW || WB > `EBR_REQ_DW) begin : g_bad_dw
         $error("port width beyond the request carrier");
      end
      if ((WA + LANE_A - 1) / LANE_A > `EBR_REQ_BW ||
          (WB + LANE_B - 1) / LANE_B > `EBR_REQ_BW) begin : g_bad_be
         $error("more byte lanes than byte enables");
      end
      if (LARGE && MODE == `EBR_MODE_ROM) begin : g_bad_rom
         $error("large block has no preload; build its rom from a dual-port write");
      end
      if (DA < 1 || DB < 1) begin : g_bad_depth
         $error("port depth below one word");
      end
   endgenerate

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      ebr_pkg::ebr_req_t a;
      ebr_pkg::ebr_req_t b;
   } ebr_in_t;
   typedef struct packed {
      logic [WA-1:0] qa;
      logic [WB-1:0] qb;
   } ebr_out_t;

   // large block output registers wake unknown, the others cleared
   localparam ebr_out_t OUT_PWR = LARGE ? 'x : '0;

   ebr_in_t in_q;
   ebr_pkg::ebr_rd_t ft_q;
   logic [BITS-1:0] mem_q;
   logic [BITS-1:0] mem_d;
   ebr_out_t out_q;
   ebr_out_t out_d;
   logic in_rst;
   ebr_pkg::ebr_rd_t rd_b;
   logic wr_a;
   logic wr_b;
   logic rd_a_en;
   logic rd_b_en;
   int base_wa;
   int base_wb;
   int base_ra;
   int base_rb;
   logic [WA-1:0] rdat_a;
   logic [WB-1:0] rdat_b;
   logic hit_a;
   logic hit_b;

   // large block clears reach only the output stage
   assign in_rst = sys_rst | (in_clr & !LARGE);

   // ****************************************************************
   // input registers
   // ****************************************************************
   // every request is captured here; cleared inputs reach the array
   // only at the following edge
   always_ff @(posedge clk or posedge in_rst) begin
      if (in_rst) begin
         in_q <= '0;
      end else begin
         in_q <= '{a: req_a, b: req_b};
      end
   end

   // ****************************************************************
   // flow-through read stage
   // ****************************************************************
   // read side only; the write side stays on the rising edge
   // falling-edge read stage gives a half-cycle read path
   always_ff @(negedge clk or posedge in_rst) begin
      if (in_rst) begin
         ft_q <= '0;
      end else begin
         ft_q <= '{rd: req_b.rd, addr: req_b.addr};
      end
   end

   // ****************************************************************
   // decode
   // ****************************************************************
   always_comb begin
      rd_b = FLOW_THRU ? ft_q : '{rd: in_q.b.rd, addr: in_q.b.addr};
      // single port: a write owns the cycle, the read yields
      wr_a = A_WR & in_q.a.wr;
      wr_b = B_WR & in_q.b.wr;
      rd_a_en = A_RD & in_q.a.rd & !((MODE == `EBR_MODE_SP) & in_q.a.wr);
      rd_b_en = B_RD & rd_b.rd;
      base_wa = (int'(in_q.a.addr) % DA) * WA;
      base_ra = base_wa;
      base_wb = (int'(in_q.b.addr) % DB) * WB + (SPLIT ? SPAN : 0);
      base_rb = (int'(rd_b.addr) % DB) * WB + (SPLIT ? SPAN : 0);
   end

   // ****************************************************************
   // write masks
   // ****************************************************************
   // one enable per bit: the port write gated by its lane's byte
   // enable; classes without byte enables write whole words
   logic [WA-1:0] wmask_a;
   logic [WB-1:0] wmask_b;

   generate
      for (genvar i = 0; i < WA; i++) begin : g_mask_a
         assign wmask_a[i] = wr_a & (!BE_A | in_q.a.be[i / LANE_A]);
      end
      for (genvar i = 0; i < WB; i++) begin : g_mask_b
         assign wmask_b[i] = wr_b & (!BE_B | in_q.b.be[i / LANE_B]);
      end
   endgenerate

   // ****************************************************************
   // array and self-timed write
   // ****************************************************************
   // the write lands on the edge after capture, so no user write pulse
   always_comb begin
      mem_d = mem_q;
      for (int i = 0; i < WA; i++) begin
         if (wmask_a[i]) begin
            mem_d[base_wa + i] = in_q.a.data[i];
         end
      end
      // both ports writing one word: port b lands last
      for (int i = 0; i < WB; i++) begin
         if (wmask_b[i]) begin
            mem_d[base_wb + i] = in_q.b.data[i];
         end
      end
   end

   // no reset: contents are never cleared, so a large-block rom is
   // loaded by writes and then left with write enables low
   always_ff @(posedge clk) begin
      mem_q <= mem_d;
   end

   // ****************************************************************
   // collision detect
   // ****************************************************************
   // bit ranges are compared, so ports of mixed width collide on any
   // shared bit, not only on equal addresses
   always_comb begin
      hit_a = wr_b && (base_wb < base_ra + WA) && (base_ra < base_wb + WB);
      hit_b = wr_a && (base_wa < base_rb + WB) && (base_rb < base_wa + WA);
   end

   // ****************************************************************
   // read and collision
   // ****************************************************************
   // a read of a word the other port writes in the same cycle
   always_comb begin
      rdat_a = mem_q[base_ra +: WA];
      rdat_b = mem_q[base_rb +: WB];
      if (hit_a && (LARGE || !RDW_OLD)) begin
         rdat_a = 'x;
      end
      if (hit_b && (LARGE || !RDW_OLD)) begin
         rdat_b = 'x;
      end
   end

   // ****************************************************************
   // output registers
   // ****************************************************************
   always_comb begin
      out_d = out_q;
      // single port shows a fresh write on the next edge through the
      // registered path
      if (rd_a_en || ((MODE == `EBR_MODE_SP) && wr_a)) begin
         out_d.qa = (MODE == `EBR_MODE_SP && wr_a) ? in_q.a.data[WA-1:0] : rdat_a;
      end
      if (rd_b_en) begin
         out_d.qb = rdat_b;
      end
   end

   // power-up value differs by class; a user clear always zeroes, so
   // the two clears stay separate events with constant values
   always_ff @(posedge clk or posedge sys_rst or posedge out_clr) begin
      if (sys_rst) begin
         out_q <= OUT_PWR;
      end else if (out_clr) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   // bypassed ports read the array through the address register; the
   // output clear acts at once only on the registered path
   assign q_a = OUT_REG_A ? out_q.qa : rdat_a;
   assign q_b = OUT_REG_B ? out_q.qb : rdat_b;
endmodule
`default_nettype wire

/* File: rtl/ebr_defs.svh */
// constants for the embedded ram block: size classes, modes, geometry
// assumes inclusion by bare name from the package and the block
`ifndef EBR_DEFS_SVH
`define EBR_DEFS_SVH
// size classes
`define EBR_CLS_SMALL 2'h0
`define EBR_CLS_MEDIUM 2'h1
`define EBR_CLS_LARGE 2'h2
// storage bits per class, parity included
`define EBR_BITS_SMALL 20'h0_0240
`define EBR_BITS_MEDIUM 20'h0_1200
`define EBR_BITS_LARGE 20'h9_0000
// widest port per class, and narrowest large-block port
`define EBR_WMAX_SMALL 8'h12
`define EBR_WMAX_MEDIUM 8'h24
`define EBR_WMAX_LARGE 8'h90
`define EBR_WMIN_LARGE 8'h08
// operating modes
`define EBR_MODE_SDP 3'h0
`define EBR_MODE_TDP 3'h1
`define EBR_MODE_SP 3'h2
`define EBR_MODE_ROM 3'h3
`define EBR_MODE_SPLIT 3'h4
// byte lanes: plain byte, byte with parity
`define EBR_LANE_PLAIN 4'h8
`define EBR_LANE_PAR 4'h9
// carrier field sizes
`define EBR_REQ_AW 16
`define EBR_REQ_DW 144
`define EBR_REQ_BW 16
`endif

/* File: rtl/ebr_pkg.sv */
// types shared by the embedded ram block and its users
// assumes ebr_defs.svh is on the include path
`include "ebr_defs.svh"
package ebr_pkg;
   // one port request as user logic presents it
   typedef struct packed {
      logic wr;
      logic rd;
      logic [`EBR_REQ_AW-1:0] addr;
      logic [`EBR_REQ_DW-1:0] data;
      logic [`EBR_REQ_BW-1:0] be;
   } ebr_req_t;
   // read address and enable as taken by the falling-edge stage
   typedef struct packed {
      logic rd;
      logic [`EBR_REQ_AW-1:0] addr;
   } ebr_rd_t;
endpackage

/* File: testbench/ebr_ram_block_sva.sv */
// checker for the ram block in simple dual-port use: port a writes, port b reads
// assumes 36-bit words, registered read output, old data on collision
`timescale 1ns/1ns
`default_nettype none
module ebr_ram_block_sva #(
   parameter int WB = 36
) (
   input wire logic clk, // block clock
   input wire logic sys_rst, // async reset
   input wire logic in_clr, // input register clear
   input wire logic out_clr, // output register clear
   input wire ebr_pkg::ebr_req_t req_a, // write port
   input wire ebr_pkg::ebr_req_t req_b, // read port
   input wire logic [WB-1:0] q_b // read data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd(logic [15:0] ad);
      req_b.rd && req_b.addr == ad && !req_a.wr && !in_clr;
   endsequence
   // output loads one edge after the read is taken
   sequence s_quiet;
      (!out_clr && !in_clr) ##1 !out_clr;
   endsequence
   property p_lane(logic m);
      logic [15:0] ad;
      logic [WB-1:0] d;
      logic [8:0] e;
      (req_a.wr && req_a.be[3:0] == 4'hf && !in_clr, ad = req_a.addr, d = req_a.data[WB-1:0])
         ##1 (req_a.wr && req_a.addr == ad && req_a.be[3:0] == {3'h0, m} && !in_clr,
         e = req_a.data[8:0]) ##1 s_rd(ad) ##1 s_quiet |-> q_b == {d[WB-1:9], m ? e : d[8:0]};
   endproperty
   property p_readback;
      logic [15:0] ad;
      logic [WB-1:0] d;
      (req_a.wr && req_a.be[3:0] == 4'hf && !in_clr, ad = req_a.addr, d = req_a.data[WB-1:0])
         ##1 s_rd(ad) ##1 s_quiet |-> q_b == d;
   endproperty
   a_reset_out_clear: assert property (disable iff (1'b0) sys_rst |-> q_b == '0)
      else $error("read data not cleared in reset");
   a_out_clr_zero: assert property (out_clr |-> q_b == '0)
      else $error("output clear not immediate");
   a_clr_stays_zero: assert property ((out_clr && !req_b.rd) ##1 (!out_clr && !req_b.rd)
      |=> q_b == '0) else $error("cleared output changed without a read");
   a_q_holds_idle: assert property (!req_b.rd ##2 !out_clr |-> $stable(q_b))
      else $error("read data moved without a read");
   a_in_clr_kills: assert property (in_clr ##2 !out_clr |-> $stable(q_b))
      else $error("input clear did not cancel the read");
   a_write_read_back: assert property (p_readback)
      else $error("read after write returned wrong word");
   a_be_none_kept: assert property (p_lane(1'b0))
      else $error("masked write changed the word");
   a_be_lane_only: assert property (p_lane(1'b1))
      else $error("lane write touched other lanes");
endmodule
`default_nettype wire

/* File: testbench/ebr_fabric.sv */
// fabric user logic launching requests: port a writes, port b reads
// assumes the bench sets its inputs just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module ebr_fabric (
   input wire logic clk, // block clock
   input wire logic wr, // write request
   input wire logic rd, // read request
   input wire logic [15:0] wa, // write word address
   input wire logic [15:0] ra, // read word address
   input wire logic [35:0] wd, // write data
   input wire logic [3:0] be, // lane enables
   output var ebr_pkg::ebr_req_t req_a, // write port request
   output var ebr_pkg::ebr_req_t req_b // read port request
);
   initial begin
      req_a = '0;
      req_b = '0;
   end
   // falling-edge launch gives the block half a cycle of setup
   always @(negedge clk) begin
      req_a.wr <= wr;
      req_a.rd <= rd; // refused on the write-only port
      req_a.addr <= wa;
      req_a.data <= wr ? {108'h0, wd} : ~req_a.data; // idle data never rests
      req_a.be <= {12'h000, be};
      req_b.wr <= wr; // refused on the read-only port
      req_b.rd <= rd;
      req_b.addr <= ra;
      req_b.data <= ~req_b.data;
      req_b.be <= {12'h000, be};
   end
endmodule
`default_nettype wire

/* File: testbench/test_ebr_ram_block.sv */
// self-checking bench: medium block, simple dual-port, registered read
// assumes the fabric model launches requests on the falling edge
`include "ebr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module test_ebr_ram_block;
   logic clk, sys_rst, in_clr, out_clr, wr, rd;
   logic [15:0] wa, ra;
   logic [35:0] wd, q_b;
   logic [3:0] be;
   ebr_pkg::ebr_req_t req_a, req_b;
   int mismatches, num_checks, cycles;
   ebr_fabric fab (.clk(clk), .wr(wr), .rd(rd), .wa(wa), .ra(ra), .wd(wd), .be(be),
      .req_a(req_a), .req_b(req_b));
   ebr_ram_block #(.CLS(`EBR_CLS_MEDIUM), .MODE(`EBR_MODE_SDP), .WA(36), .WB(36),
      .OUT_REG_A(1'b1), .OUT_REG_B(1'b1), .RDW_OLD(1'b1), .FLOW_THRU(1'b0)) uut (
      .clk(clk), .sys_rst(sys_rst), .in_clr(in_clr), .out_clr(out_clr),
      .req_a(req_a), .req_b(req_b), .q_a(), .q_b(q_b));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [35:0] seen, input logic [35:0] want);
      num_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("Error at %0t: read %h expected %h", $time, seen, want);
      end
   endtask
   task automatic op(input logic w, input logic r, input logic [15:0] a,
      input logic [35:0] d, input logic [3:0] b, input logic [15:0] ra_i);
      wr = w;
      rd = r;
      wa = a;
      wd = d;
      be = b;
      ra = ra_i;
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [35:0] want);
      op(1'b0, 1'b1, 16'h0000, 36'h0, 4'h0, a);
      op(1'b0, 1'b0, 16'h0000, 36'h0, 4'h0, 16'h0000);
      #1;
      check(q_b, want);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // a hang counts as a failure
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      {sys_rst, in_clr, out_clr, wr, rd, wa, ra, wd, be} = '0;
      sys_rst = 1'b1;
      {mismatches, num_checks, cycles} = '0;
      repeat (12) @(posedge clk);
      #1 check(q_b, 36'h0);
      @(negedge clk) sys_rst = 1'b0;
      @(posedge clk);
      op(1'b1, 1'b0, 16'h0003, 36'h1_2345_6789, 4'hf, 16'h0000);
      op(1'b1, 1'b0, 16'h007f, 36'hf_edcb_a987, 4'hf, 16'h0000);
      op(1'b1, 1'b0, 16'h0005, 36'h5_5555_5555, 4'hf, 16'h0000);
      rdchk(16'h0003, 36'h1_2345_6789);
      rdchk(16'h007f, 36'hf_edcb_a987);
      op(1'b1, 1'b0, 16'h0011, 36'h3_c3c3_c3c3, 4'hf, 16'h0000);
      rdchk(16'h0011, 36'h3_c3c3_c3c3);
      op(1'b1, 1'b0, 16'h0003, 36'h0_0000_0000, 4'h1, 16'h0000);
      rdchk(16'h0003, 36'h1_2345_6600);
      op(1'b1, 1'b0, 16'h0009, 36'h9_8765_4321, 4'hf, 16'h0000);
      op(1'b1, 1'b0, 16'h0009, 36'h0_1111_1111, 4'h0, 16'h0000);
      rdchk(16'h0009, 36'h9_8765_4321);
      // same word written and read in one cycle keeps the old word
      op(1'b1, 1'b1, 16'h0005, 36'h0_aaaa_aaaa, 4'hf, 16'h0005);
      op(1'b0, 1'b0, 16'h0000, 36'h0, 4'h0, 16'h0000);
      #1 check(q_b, 36'h5_5555_5555);
      rdchk(16'h0005, 36'h0_aaaa_aaaa);
      op(1'b0, 1'b1, 16'h0000, 36'h0, 4'h0, 16'h0003);
      rd = 1'b0;
      @(negedge clk) in_clr = 1'b1;
      #1 check(q_b, 36'h0_aaaa_aaaa);
      @(negedge clk) in_clr = 1'b0;
      @(posedge clk) #1 check(q_b, 36'h0_aaaa_aaaa);
      rdchk(16'h007f, 36'hf_edcb_a987);
      @(negedge clk) out_clr = 1'b1;
      #1 check(q_b, 36'h0);
      @(negedge clk) out_clr = 1'b0;
      @(posedge clk) #1 check(q_b, 36'h0);
      rdchk(16'h0011, 36'h3_c3c3_c3c3);
      op(1'b1, 1'b0, 16'h0020, 36'h7_0f0f_0f0f, 4'hf, 16'h0000);
      op(1'b1, 1'b0, 16'h0020, 36'h0_0000_0155, 4'h1, 16'h0000);
      rdchk(16'h0020, 36'h7_0f0f_0f55);
      print_verdict();
   end
endmodule
bind ebr_ram_block ebr_ram_block_sva #(.WB(WB)) u_sva (.clk(clk), .sys_rst(sys_rst),
   .in_clr(in_clr), .out_clr(out_clr), .req_a(req_a), .req_b(req_b), .q_b(q_b));
`default_nettype wire
